//--- inc/pam_pkg.sv
package pam_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_CTRL     = 8'h0c;
  localparam logic [7:0] REG_MSG      = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int IRQ_W        = 5;
  localparam int IRQ_CPU      = 0;
  localparam int IRQ_MEM      = 1;
  localparam int IRQ_NOEND    = 2;
  localparam int IRQ_COMM     = 3;
  localparam int IRQ_ENTRY    = 4;
  localparam int CTRL_WDT_EN  = 0;
  localparam int CTRL_KICK    = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
  localparam logic             WDT_EN_RST   = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned WDT_TIME_MS = 100;
  localparam int unsigned WDT_CYCLES  = WDT_TIME_MS * (CLK_HZ / 1000);
  localparam int          WDT_W       = 24;
  localparam int          MSG_DEPTH   = 8;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MSG_CHECK_OK    = 3'h0,
    MSG_MEMORY_ERR  = 3'h1,
    MSG_MISSING_END = 3'h2,
    MSG_CPU_ERR     = 3'h3,
    MSG_COMM_FAULT  = 3'h4,
    MSG_TOO_LARGE   = 3'h5,
    MSG_ADDR_OVER   = 3'h6,
    MSG_OPERAND_ERR = 3'h7
  } pam_msg_e;

  typedef struct packed {
    logic mem_fault;
    logic missing_end;
    logic comm_fault;
    logic link_up;
    logic power_ok;
    logic prog_mode;
  } pam_fault_s;

  typedef struct packed {
    logic req;
    logic last_is_noop;
    logic addr_over;
    logic operand_bad;
  } pam_entry_s;

  typedef struct packed {
    logic power;
    logic run;
    logic error;
    logic link;
  } pam_led_s;

endpackage

//--- src/pam_alarm_mgr.sv
// Local design decisions: the AXI4-Lite register port and the register addresses.
module pam_alarm_mgr
  import pam_pkg::*;
#(
  parameter int unsigned WDT_LIMIT = WDT_CYCLES,
  parameter int          DEPTH     = MSG_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Controller status and faults
  input  wire pam_fault_s  fault,
  input  wire pam_entry_s  entry,
  // Console keys
  input  wire logic        next_message_key,
  input  wire logic        clear_key,
  // Console answers
  output pam_msg_e         console_msg,
  output logic             console_valid,
  output pam_msg_e         entry_msg,
  output logic             entry_done,
  output logic             link_restore,
  // Controller control
  output pam_led_s         led,
  output logic             program_run_en,
  output logic             outputs_off,
  output logic             irq
);

  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic             aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0]       waddr_r, waddr_nxt;
  logic [31:0]      wdata_r, wdata_nxt;
  logic             wlane_r, wlane_nxt;
  logic             awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0]       bresp_nxt, rresp_nxt;
  logic [31:0]      rdata_nxt;
  logic             do_write;
  logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt, events;
  logic             wdt_en_r, wdt_en_nxt, kick;
  logic             fatal_r, comm_r;
  pam_msg_e         mem_q [DEPTH];
  logic [PW-1:0]    head_r, tail_r, view_r;
  logic [PW:0]      cnt_r;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == REG_STATUS) || (a == REG_IRQ_STAT) || (a == REG_IRQ_MASK) ||
              (a == REG_CTRL) || (a == REG_MSG);
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    rd_word = 32'h0000_0000;
    unique case (a)
      REG_STATUS:   rd_word = {24'h00_0000, 3'h0, !fault.prog_mode && !fatal_r,
                               fault.prog_mode, comm_r, fatal_r, wdt_en_r};
      REG_IRQ_STAT: rd_word = {27'h000_0000, irq_stat_r};
      REG_IRQ_MASK: rd_word = {27'h000_0000, irq_mask_r};
      REG_CTRL:     rd_word = {31'h0000_0000, wdt_en_r};
      REG_MSG:      rd_word = {24'h00_0000, 1'b0, mem_q[head_r], 4'(cnt_r)};
      default:      rd_word = 32'h0000_0000;
    endcase
  endfunction

  always_comb begin
    aw_got_nxt  = aw_got_r | (s_axi_awvalid & s_axi_awready);
    w_got_nxt   = w_got_r | (s_axi_wvalid & s_axi_wready);
    waddr_nxt   = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : waddr_r;
    wdata_nxt   = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_r;
    wlane_nxt   = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : wlane_r;
    bvalid_nxt  = s_axi_bvalid & !s_axi_bready;
    bresp_nxt   = s_axi_bresp;
    do_write    = aw_got_nxt & w_got_nxt & !bvalid_nxt;
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = reg_hit(waddr_nxt) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_nxt = !aw_got_nxt & !bvalid_nxt;
    wready_nxt  = !w_got_nxt & !bvalid_nxt;
    rvalid_nxt  = s_axi_rvalid & !s_axi_rready;
    rdata_nxt   = s_axi_rdata;
    rresp_nxt   = s_axi_rresp;
    if (s_axi_arvalid & s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_word(s_axi_araddr);
      rresp_nxt  = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    arready_nxt = !rvalid_nxt;
    // Register write effects; hardware events win over a clear
    irq_mask_nxt = irq_mask_r;
    wdt_en_nxt   = wdt_en_r;
    kick         = 1'b0;
    irq_stat_nxt = irq_stat_r;
    if (do_write && wlane_nxt) begin
      unique case (waddr_nxt)
        REG_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~wdata_nxt[IRQ_W-1:0];
        REG_IRQ_MASK: irq_mask_nxt = wdata_nxt[IRQ_W-1:0];
        REG_CTRL: begin
          wdt_en_nxt = wdata_nxt[CTRL_WDT_EN];
          kick       = wdata_nxt[CTRL_KICK];
        end
        default: ;
      endcase
    end
    irq_stat_nxt = irq_stat_nxt | events;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      waddr_r       <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wlane_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      irq_stat_r    <= 5'h00;
      irq_mask_r    <= IRQ_MASK_RST;
      wdt_en_r      <= WDT_EN_RST;
      irq           <= 1'b0;
    end else begin
      aw_got_r      <= aw_got_nxt;
      w_got_r       <= w_got_nxt;
      waddr_r       <= waddr_nxt;
      wdata_r       <= wdata_nxt;
      wlane_r       <= wlane_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready  <= wready_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rdata   <= rdata_nxt;
      s_axi_rresp   <= rresp_nxt;
      irq_stat_r    <= irq_stat_nxt;
      irq_mask_r    <= irq_mask_nxt;
      wdt_en_r      <= wdt_en_nxt;
      irq           <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // ----------------------------------------------------------------
  // Fault classification, watchdog and indicators
  // ----------------------------------------------------------------
  logic [WDT_W-1:0] wdt_r, wdt_nxt;
  logic             wdt_exp, running, fatal_nxt, comm_nxt, key_ok;
  logic             push, pop;
  pam_msg_e         push_code, entry_code;
  logic             entry_bad;
  logic [PW:0]      cnt_nxt;

  assign running = !fault.prog_mode && !fatal_r;
  assign key_ok  = next_message_key && !comm_r;

  always_comb begin
    wdt_nxt = (!running || !wdt_en_r || kick) ? '0 : wdt_r + 1'b1;
    wdt_exp = running && wdt_en_r && !kick && (wdt_r == WDT_W'(WDT_LIMIT - 1));
    entry_bad  = 1'b1;
    entry_code = MSG_CHECK_OK;
    if (!entry.last_is_noop) begin
      entry_code = MSG_TOO_LARGE;
    end else if (entry.addr_over) begin
      entry_code = MSG_ADDR_OVER;
    end else if (entry.operand_bad) begin
      entry_code = MSG_OPERAND_ERR;
    end else begin
      entry_bad = 1'b0;
    end
    events = '0;
    events[IRQ_CPU]   = wdt_exp;
    events[IRQ_MEM]   = fault.mem_fault;
    events[IRQ_NOEND] = fault.missing_end && !fault.prog_mode;
    events[IRQ_COMM]  = fault.comm_fault;
    events[IRQ_ENTRY] = entry.req && entry_bad;
    fatal_nxt = fatal_r | events[IRQ_CPU] | events[IRQ_MEM] | events[IRQ_NOEND];
    if (fault.prog_mode && (cnt_nxt == '0) && !(|events[IRQ_NOEND:IRQ_CPU])) begin
      fatal_nxt = 1'b0;
    end
    comm_nxt = fault.comm_fault | (comm_r & !clear_key);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wdt_r          <= '0;
      fatal_r        <= 1'b0;
      comm_r         <= 1'b0;
      entry_msg      <= MSG_CHECK_OK;
      entry_done     <= 1'b0;
      link_restore   <= 1'b0;
      led            <= '0;
      program_run_en <= 1'b0;
      outputs_off    <= 1'b0;
    end else begin
      wdt_r          <= wdt_nxt;
      fatal_r        <= fatal_nxt;
      comm_r         <= comm_nxt;
      entry_msg      <= entry.req ? entry_code : entry_msg;
      entry_done     <= entry.req;
      link_restore   <= comm_r && clear_key && !fault.comm_fault;
      led.power      <= fault.power_ok;
      led.run        <= !fault.prog_mode && !fatal_nxt;
      led.error      <= fatal_nxt;
      led.link       <= fault.link_up && !comm_nxt;
      program_run_en <= !fault.prog_mode && !fatal_nxt;
      outputs_off    <= fatal_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Message store
  // ----------------------------------------------------------------
  logic [PW-1:0] head_nxt, tail_nxt, view_nxt;
  pam_msg_e      show_nxt;

  always_comb begin
    // One message per cycle: only the most severe event is stored, the others that cycle are dropped
    push      = 1'b1;
    push_code = MSG_CHECK_OK;
    if (events[IRQ_CPU]) begin
      push_code = MSG_CPU_ERR;
    end else if (events[IRQ_MEM]) begin
      push_code = MSG_MEMORY_ERR;
    end else if (events[IRQ_NOEND]) begin
      push_code = MSG_MISSING_END;
    end else if (events[IRQ_COMM]) begin
      push_code = MSG_COMM_FAULT;
    end else if (events[IRQ_ENTRY]) begin
      push_code = entry_code;
    end else begin
      push = 1'b0;
    end
    pop      = key_ok && fault.prog_mode && (cnt_r != '0);
    push     = push && ((cnt_r != (PW+1)'(DEPTH)) || pop);
    head_nxt = pop ? head_r + 1'b1 : head_r;
    tail_nxt = push ? tail_r + 1'b1 : tail_r;
    cnt_nxt  = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    view_nxt = pop ? head_nxt : view_r;
    show_nxt = console_msg;
    if (key_ok) begin
      if (cnt_r == '0) begin
        show_nxt = MSG_CHECK_OK;
      end else if (fault.prog_mode) begin
        show_nxt = mem_q[head_r];
      end else begin
        show_nxt = mem_q[view_r];
        view_nxt = (view_r + 1'b1 == tail_r) ? head_r : view_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      head_r        <= '0;
      tail_r        <= '0;
      view_r        <= '0;
      cnt_r         <= '0;
      console_msg   <= MSG_CHECK_OK;
      console_valid <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= MSG_CHECK_OK;
      end
    end else begin
      head_r        <= head_nxt;
      tail_r        <= tail_nxt;
      view_r        <= view_nxt;
      cnt_r         <= cnt_nxt;
      console_msg   <= show_nxt;
      console_valid <= key_ok;
      if (push) begin
        mem_q[tail_r] <= push_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_prog_pop;
    key_ok && fault.prog_mode && (cnt_r != '0) && !push;
  endsequence

  sequence seq_empty_key;
    key_ok && (cnt_r == '0);
  endsequence

  AST_FATAL_HALT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fatal_r |-> outputs_off && !program_run_en && led.error)
    else $error("fatal fault left outputs or program running");

  AST_NONFATAL_RUN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(!fault.prog_mode) && !fatal_r |-> program_run_en && !outputs_off)
    else $error("non-fatal state halted program");

  AST_WDT_FATAL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wdt_exp |=> fatal_r && led.error && !led.run)
    else $error("watchdog expiry not fatal");

  AST_MEM_FATAL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fault.mem_fault |=> fatal_r && outputs_off)
    else $error("memory fault not fatal");

  AST_NOEND_FATAL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fault.missing_end && !fault.prog_mode |=> fatal_r && !program_run_en)
    else $error("missing end not fatal");

  AST_RUN_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !fault.prog_mode |=> cnt_r >= $past(cnt_r))
    else $error("message removed in run mode");

  AST_PROG_POP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_prog_pop |=> (cnt_r == $past(cnt_r) - 1'b1) && console_valid)
    else $error("program mode read did not remove message");

  AST_ALL_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_empty_key |=> console_valid && (console_msg == MSG_CHECK_OK))
    else $error("empty store did not answer all-clear");

  AST_COMM_IGNORE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    comm_r && next_message_key |=> !console_valid)
    else $error("key accepted during comm fault");

  AST_LINK_DARK: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fault.comm_fault |=> !led.link ##1 (!led.link || $past(clear_key)))
    else $error("link indicator lit after comm fault");

  AST_TOO_LARGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    entry.req && !entry.last_is_noop |=> entry_done && (entry_msg == MSG_TOO_LARGE))
    else $error("missing too-large answer");

endmodule

//--- tb/pam_console_model.sv
module pam_console_model
  import pam_pkg::*;
(
  // Clock
  input  wire logic     clk_sys,
  // Answers from the controller
  input  wire pam_msg_e console_msg,
  input  wire logic     console_valid,
  input  wire logic     link_restore,
  // Keys
  output logic          next_message_key,
  output logic          clear_key
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    next_message_key = 1'b0;
    clear_key = 1'b0;
  end

  // ----------------------------------------------------------------
  // Key press
  // ----------------------------------------------------------------
  // one key, then wait for its answer
  task automatic press(input logic clr, output logic got, output pam_msg_e m);
    got = 1'b0;
    m = MSG_CHECK_OK;
    @(posedge clk_sys);
    if (clr) clear_key <= 1'b1;
    else next_message_key <= 1'b1;
    @(posedge clk_sys);
    clear_key <= 1'b0;
    next_message_key <= 1'b0;
    repeat (3) begin
      #1;
      if (!got && (clr ? link_restore : console_valid) === 1'b1) begin
        got = 1'b1;
        m = console_msg;
      end
      @(posedge clk_sys);
    end
  endtask
endmodule

//--- tb/tb.sv
module tb
  import pam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_sys, rst_b;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  pam_fault_s  fault;
  pam_entry_s  entry;
  logic        next_message_key, clear_key, console_valid, entry_done;
  logic        link_restore, program_run_en, outputs_off, irq;
  pam_msg_e    console_msg, entry_msg;
  pam_led_s    led;
  int          fail_count  = 0;
  int          comparisons = 0;
  localparam int WDT_SIM = 20;

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  pam_alarm_mgr #(.WDT_LIMIT(WDT_SIM)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fault(fault), .entry(entry),
    .next_message_key(next_message_key), .clear_key(clear_key),
    .console_msg(console_msg), .console_valid(console_valid),
    .entry_msg(entry_msg), .entry_done(entry_done), .link_restore(link_restore),
    .led(led), .program_run_en(program_run_en), .outputs_off(outputs_off),
    .irq(irq)
  );

  pam_console_model u_con (
    .clk_sys(clk_sys), .console_msg(console_msg), .console_valid(console_valid),
    .link_restore(link_restore), .next_message_key(next_message_key),
    .clear_key(clear_key)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic pop_expect(input logic [2:0] e);
    logic     got;
    pam_msg_e m;
    u_con.press(1'b0, got, m);
    chk("console_valid", 1, got);
    chk("console_msg", e, m);
  endtask

  task automatic pulse_fault(input pam_fault_s f);
    @(posedge clk_sys);
    fault <= fault | f;
    @(posedge clk_sys);
    fault <= fault & 6'h07;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axr(REG_IRQ_MASK, d, r);
    chk("mask reset", 0, d);
    axr(REG_CTRL, d, r);
    chk("ctrl reset", 1, d);
    axr(8'h20, d, r);
    chk("unmapped rresp", RESP_SLVERR, r);
    axw(8'h24, 32'h1, r);
    chk("unmapped bresp", RESP_SLVERR, r);
  endtask

  task automatic sc_entry();
    logic [3:0] ev [4] = '{4'hb, 4'he, 4'hd, 4'hc};
    logic [2:0] ex [4] = '{3'h5, 3'h6, 3'h7, 3'h0};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      entry <= ev[i];
      @(posedge clk_sys);
      entry <= '0;
      #1;
      chk("entry_done", 1, entry_done);
      chk("entry_msg", ex[i], entry_msg);
    end
    settle(1);
    chk("outputs_off", 0, outputs_off);
    chk("error led", 0, led.error);
    chk("irq masked", 0, irq);
    pop_expect(3'h5);
    pop_expect(3'h6);
    pop_expect(3'h7);
    pop_expect(3'h0);
  endtask

  task automatic sc_fatal();
    logic [31:0] d;
    logic [1:0]  r;
    axw(REG_IRQ_MASK, 32'h2, r);
    @(posedge clk_sys);
    fault <= 6'h26;
    @(posedge clk_sys);
    fault <= 6'h16;
    @(posedge clk_sys);
    fault <= 6'h06;
    settle(2);
    chk("error led", 1, led.error);
    chk("outputs_off", 1, outputs_off);
    chk("run enable", 0, program_run_en);
    chk("power led", 1, led.power);
    chk("run led", 0, led.run);
    chk("irq", 1, irq);
    pop_expect(3'h1);
    pop_expect(3'h2);
    pop_expect(3'h1);
    axr(REG_MSG, d, r);
    chk("msg count", 2, d[3:0]);
    axw(REG_IRQ_STAT, 32'h2, r);
    settle(1);
    chk("irq cleared", 0, irq);
    axr(REG_IRQ_STAT, d, r);
    chk("irq status", 32'h14, d);
    @(posedge clk_sys);
    fault <= 6'h07;
    pop_expect(3'h1);
    pop_expect(3'h2);
    pop_expect(3'h0);
    settle(2);
    chk("error led off", 0, led.error);
    chk("outputs_off", 0, outputs_off);
  endtask

  task automatic sc_wdt();
    int         n = 0;
    logic [1:0] r;
    @(posedge clk_sys);
    fault <= 6'h06;
    repeat (10) @(posedge clk_sys);
    axw(REG_CTRL, 32'h3, r);
    while (outputs_off !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    chk("wdt span", WDT_SIM, n);
    settle(1);
    chk("power led", 1, led.power);
    chk("run led", 0, led.run);
    chk("error led", 1, led.error);
    @(posedge clk_sys);
    fault <= 6'h07;
    pop_expect(3'h3);
    pop_expect(3'h0);
  endtask

  task automatic sc_comm();
    logic        got;
    pam_msg_e    m;
    logic [31:0] d;
    logic [1:0]  r;
    axw(REG_CTRL, 32'h0, r);
    axr(REG_CTRL, d, r);
    chk("ctrl wdt off", 0, d);
    @(posedge clk_sys);
    fault <= 6'h06;
    pulse_fault(6'h08);
    settle(2);
    chk("link led", 0, led.link);
    chk("run enable", 1, program_run_en);
    chk("outputs_off", 0, outputs_off);
    u_con.press(1'b0, got, m);
    chk("key ignored", 0, got);
    u_con.press(1'b1, got, m);
    chk("link_restore", 1, got);
    settle(1);
    chk("link led", 1, led.link);
    pop_expect(3'h4);
    @(posedge clk_sys);
    fault <= 6'h07;
    pop_expect(3'h4);
    pop_expect(3'h0);
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    fault = 6'h07;
    entry = '0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    sc_regs();
    sc_entry();
    sc_fatal();
    sc_wdt();
    sc_comm();
    tally_and_finish();
  end

  initial begin
    #100us;
    fail_count++;
    tally_and_finish();
  end
endmodule
